// ==== bench/ddg_top_bench.sv ====
// self-checking bench for the damping and detector gain register bank
`timescale 1ns/1ps
module ddg_top_bench;
  import ddg_pkg::*;
  // ==========================================================
  // stimulus and observed signals
  logic       clock = 1'b0;  // 10 MHz clock
  logic       rst   = 1'b1;  // synchronous reset
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic       reg_wr = 1'b0, reg_rd = 1'b0;
  logic [1:0] loop_b_bw_field = 2'h0, loop_a_bw_field = 2'h3;
  logic       loop_b_detector_gain_on = 1'b0, loop_b_analog_mode = 1'b0;
  logic       loop_b_locking = 1'b0, loop_a_gain_sel_on = 1'b0;
  logic       loop_a_analog_mode = 1'b0, loop_a_ref_8k = 1'b0;
  logic       loop_a_locking = 1'b0;
  logic [7:0] loop_b_damp_factor, loop_a_damp_factor;
  logic [5:0] loop_b_gain_peak, loop_a_gain_peak;
  logic [2:0] loop_b_detector_gain, loop_a_detector_gain;
  logic       loop_b_detector_gain_act, loop_a_detector_gain_act;
  int         n_mismatch = 0;  // mismatches seen
  int         tests_run  = 0;  // comparisons made
  int         cycles     = 0;  // hang guard

  // ==========================================================
  // design under test
  ddg_top DUT (
    .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .loop_b_bw_field(loop_b_bw_field),
    .loop_b_detector_gain_on(loop_b_detector_gain_on),
    .loop_b_analog_mode(loop_b_analog_mode),
    .loop_b_locking(loop_b_locking), .loop_a_bw_field(loop_a_bw_field),
    .loop_a_gain_sel_on(loop_a_gain_sel_on),
    .loop_a_analog_mode(loop_a_analog_mode),
    .loop_a_ref_8k(loop_a_ref_8k), .loop_a_locking(loop_a_locking),
    .loop_b_damp_factor(loop_b_damp_factor),
    .loop_b_gain_peak(loop_b_gain_peak),
    .loop_b_detector_gain(loop_b_detector_gain),
    .loop_b_detector_gain_act(loop_b_detector_gain_act),
    .loop_a_damp_factor(loop_a_damp_factor),
    .loop_a_gain_peak(loop_a_gain_peak),
    .loop_a_detector_gain(loop_a_detector_gain),
    .loop_a_detector_gain_act(loop_a_detector_gain_act)
  );

  // ==========================================================
  // clock and hang guard
  always #50 clock = ~clock;
  // the whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch++;
      report_and_stop;
    end
  end

  // ==========================================================
  // helpers
  // prints counts and verdict, then ends the run
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // compares one value, four-state exact
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
                     input string what);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what,
               seen, exp);
    end
  endtask

  // one-cycle write strobe
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask

  // one-cycle read strobe, data taken after the taking edge
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // lets register and decoded outputs land
  task automatic settle;
    repeat (2) @(posedge clock);
    #1;
  endtask

  // expected damping factor in tenths, col 0/1/2 = 18/35/70 Hz
  function automatic logic [7:0] exp_df(input logic [2:0] c, input int col);
    case (c)
      3'h1: return 8'h0C;
      3'h2: return 8'h19;
      3'h3: return 8'h32;
      3'h4: return (col == 0) ? 8'h32 : 8'h64;
      3'h5: return (col == 0) ? 8'h32 : (col == 1) ? 8'h64 : 8'hC8;
      default: return 8'h00;
    endcase
  endfunction

  // expected gain peak in hundredths of a dB
  function automatic logic [7:0] exp_gp(input logic [7:0] df);
    case (df)
      8'h0C: return 8'h28;
      8'h19: return 8'h14;
      8'h32: return 8'h0A;
      8'h64: return 8'h06;
      8'hC8: return 8'h03;
      default: return 8'h00;
    endcase
  endfunction

  // ==========================================================
  // scenarios
  // reset contents, decoded reset codes, unmapped read
  task automatic test_reset;
    logic [7:0] d;
    settle;
    chk(loop_b_damp_factor, 8'h32, "b reset factor");
    chk(loop_a_damp_factor, 8'h32, "a reset factor");
    chk({2'h0, loop_b_gain_peak}, 8'h0A, "b reset peak");
    chk(8'(loop_b_detector_gain_act), 8'h00, "b act off");
    chk(reg_rdata, 8'h00, "rdata reset");
    reg_read(8'h6A, d);
    chk(d, 8'h13, "second reset");
    reg_read(8'h6B, d);
    chk(d, 8'h14, "first reset");
    reg_read(8'h6C, d);
    chk(d, 8'h00, "unmapped read");
    $display("test reset done");
  endtask

  // every code against every bandwidth field, unused field falls to 18 Hz
  task automatic test_damping;
    logic [7:0] e;
    for (int col = 0; col < 4; col++) begin
      for (int k = 0; k < 8; k++) begin
        @(posedge clock);
        loop_b_bw_field <= col[1:0];
        loop_a_bw_field <= (col == 0) ? 2'h3 : col[1:0] - 2'h1;
        reg_write(8'h6A, {5'h00, k[2:0]});
        reg_write(8'h6B, {5'h00, k[2:0]});
        settle;
        e = exp_df(k[2:0], (col == 3) ? 0 : col);
        chk(loop_b_damp_factor, e, "b factor");
        chk({2'h0, loop_b_gain_peak}, exp_gp(e), "b peak");
        chk(loop_a_damp_factor, e, "a factor");
        chk({2'h0, loop_a_gain_peak}, exp_gp(e), "a peak");
      end
    end
    $display("test damping done");
  endtask

  // unused bits dropped, two writes one idle cycle apart
  task automatic test_mask;
    logic [7:0] d;
    reg_write(8'h6A, 8'hFF);
    reg_write(8'h6B, 8'h88);
    reg_read(8'h6A, d);
    chk(d, 8'h77, "second mask");
    reg_read(8'h6B, d);
    chk(d, 8'h00, "first mask");
    $display("test mask done");
  endtask

  // write then read at once, and a read beside a write sees old data
  task automatic test_wr_rd;
    logic [7:0] d;
    @(posedge clock);
    reg_addr  <= 8'h6B;
    reg_wdata <= 8'hDD;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b1;
    @(posedge clock);
    reg_rd    <= 1'b0;
    #1 chk(reg_rdata, 8'h55, "readback");
    @(posedge clock);
    reg_wdata <= 8'h21;
    reg_wr    <= 1'b1;
    reg_rd    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b0;
    #1 chk(reg_rdata, 8'h55, "read beside write");
    reg_read(8'h6B, d);
    chk(d, 8'h21, "later read");
    $display("test wr rd done");
  endtask

  // detector gain gating over all enable combinations
  task automatic test_gain;
    logic ab, aa;
    logic [7:0] gb, ga;
    reg_write(8'h6A, 8'h53);
    reg_write(8'h6B, 8'h64);
    for (int i = 0; i < 16; i++) begin
      @(posedge clock);
      {loop_b_detector_gain_on, loop_b_analog_mode, loop_b_locking}
        <= i[2:0];
      {loop_a_gain_sel_on, loop_a_analog_mode, loop_a_ref_8k,
       loop_a_locking} <= i[3:0];
      settle;
      ab = &i[2:0];
      aa = &i[3:0];
      gb = ab ? 8'h05 : 8'h00;
      ga = aa ? 8'h06 : 8'h00;
      chk(8'(loop_b_detector_gain_act), 8'(ab), "b act");
      chk(8'(loop_b_detector_gain), gb, "b gain");
      chk(8'(loop_a_detector_gain_act), 8'(aa), "a act");
      chk(8'(loop_a_detector_gain), ga, "a gain");
    end
    reg_write(8'h6A, 8'h23);
    settle;
    chk({5'h0, loop_b_detector_gain}, 8'h02, "b new gain");
    $display("test gain done");
  endtask

  // reset in mid-run brings back reset contents, clears the gain enable, then gain code 1 returns
  task automatic test_mid_reset;
    logic [7:0] d;
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    #1;
    chk(reg_rdata, 8'h00, "rdata rst");
    chk(8'(loop_b_detector_gain_act), 8'h00, "b act rst");
    settle;
    chk(8'(loop_b_detector_gain), 8'h01, "b gain rst");
    chk(8'(loop_a_detector_gain), 8'h01, "a gain rst");
    chk(loop_b_damp_factor, 8'h32, "b factor rst");
    reg_read(8'h6A, d);
    chk(d, 8'h13, "second rst");
    reg_read(8'h6B, d);
    chk(d, 8'h14, "first rst");
    $display("test mid reset done");
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    test_reset;
    test_damping;
    test_mask;
    test_wr_rd;
    test_gain;
    test_mid_reset;
    report_and_stop;
  end
endmodule

// ==== hw/ddg_damp_decode.sv ====
// damping code to damping factor and gain peak decoder
`timescale 1ns/1ps
module ddg_damp_decode
  import ddg_pkg::*;
(
  // selection
  input  wire logic [2:0] code,
  input  wire ddg_bw_e    bw,
  // decoded values
  output logic      [7:0] factor,
  output logic      [5:0] peak
);

  // ==========================================================
  // damping factor from code and bandwidth column
  always_comb begin
    case (code)
      DDG_CODE_1: factor = DDG_DF_1P2;
      DDG_CODE_2: factor = DDG_DF_2P5;
      DDG_CODE_3: factor = DDG_DF_5;
      DDG_CODE_4: begin
        factor = (bw == DDG_BW_18) ? DDG_DF_5 : DDG_DF_10;
      end
      DDG_CODE_5: begin
        case (bw)
          DDG_BW_35: factor = DDG_DF_10;
          DDG_BW_70: factor = DDG_DF_20;
          default:   factor = DDG_DF_5;
        endcase
      end
      default: factor = DDG_DF_NONE;  // undefined codes
    endcase
  end

  // ==========================================================
  // gain peak follows the chosen damping factor
  always_comb begin
    case (factor)
      DDG_DF_1P2: peak = DDG_GP_1P2;
      DDG_DF_2P5: peak = DDG_GP_2P5;
      DDG_DF_5:   peak = DDG_GP_5;
      DDG_DF_10:  peak = DDG_GP_10;
      DDG_DF_20:  peak = DDG_GP_20;
      default:    peak = DDG_GP_NONE;
    endcase
  end

endmodule

// ==== hw/ddg_top.sv ====
// damping and detector gain register bank for both loops
`timescale 1ns/1ps
module ddg_top
  import ddg_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // register access port
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // second loop context
  input  wire logic [1:0] loop_b_bw_field,
  input  wire logic       loop_b_detector_gain_on,
  input  wire logic       loop_b_analog_mode,
  input  wire logic       loop_b_locking,
  // first loop context
  input  wire logic [1:0] loop_a_bw_field,
  input  wire logic       loop_a_gain_sel_on,
  input  wire logic       loop_a_analog_mode,
  input  wire logic       loop_a_ref_8k,
  input  wire logic       loop_a_locking,
  // second loop results
  output logic      [7:0] loop_b_damp_factor,
  output logic      [5:0] loop_b_gain_peak,
  output logic      [2:0] loop_b_detector_gain,
  output logic            loop_b_detector_gain_act,
  // first loop results
  output logic      [7:0] loop_a_damp_factor,
  output logic      [5:0] loop_a_gain_peak,
  output logic      [2:0] loop_a_detector_gain,
  output logic            loop_a_detector_gain_act
);

  // ==========================================================
  // storage
  logic [7:0] second_reg;     // second loop damping and gain
  logic [7:0] first_reg;      // first loop damping and gain
  ddg_bw_e    bw_b;           // second loop column
  ddg_bw_e    bw_a;           // first loop column
  logic [7:0] factor_w [2];   // decoded factor per loop
  logic [5:0] peak_w   [2];   // decoded peak per loop
  logic [2:0] code_w   [2];   // damping code per loop
  ddg_bw_e    bw_w     [2];   // bandwidth column per loop
  logic       b_gate;         // second loop gain condition
  logic       a_gate;         // first loop gain condition

  // ==========================================================
  // second loop register, unused bits never stored
  always_ff @(posedge clock) begin
    if (rst) begin
      second_reg <= DDG_RST_SECOND;
    end else if (reg_wr && reg_addr == DDG_OFS_SECOND) begin
      second_reg <= reg_wdata & DDG_WR_MASK;
    end
  end

  // first loop register, unused bits never stored
  always_ff @(posedge clock) begin
    if (rst) begin
      first_reg <= DDG_RST_FIRST;
    end else if (reg_wr && reg_addr == DDG_OFS_FIRST) begin
      first_reg <= reg_wdata & DDG_WR_MASK;
    end
  end

  // ==========================================================
  // read port, one cycle after the strobe
  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata <= DDG_RD_UNMAP;
    end else if (reg_rd) begin
      case (reg_addr)
        DDG_OFS_SECOND: reg_rdata <= second_reg;
        DDG_OFS_FIRST:  reg_rdata <= first_reg;
        default:        reg_rdata <= DDG_RD_UNMAP;  // unmapped
      endcase
    end
  end

  // ==========================================================
  // bandwidth field to table column; unused encoding uses 18 Hz
  always_comb begin
    case (loop_b_bw_field)
      DDG_B_BW_35: bw_b = DDG_BW_35;
      DDG_B_BW_70: bw_b = DDG_BW_70;
      default:     bw_b = DDG_BW_18;
    endcase
  end

  // first loop has its own field encoding
  always_comb begin
    case (loop_a_bw_field)
      DDG_A_BW_35: bw_a = DDG_BW_35;
      DDG_A_BW_70: bw_a = DDG_BW_70;
      default:     bw_a = DDG_BW_18;
    endcase
  end

  // ==========================================================
  // one decoder per loop: index 0 is first, 1 is second
  assign code_w[0] = first_reg[DDG_DAMP_LSB +: 3];
  assign code_w[1] = second_reg[DDG_DAMP_LSB +: 3];
  assign bw_w[0]   = bw_a;
  assign bw_w[1]   = bw_b;

  for (genvar i = 0; i < 2; i++) begin : g_dec
    ddg_damp_decode u_dec (
      .code   (code_w[i]),
      .bw     (bw_w[i]),
      .factor (factor_w[i]),
      .peak   (peak_w[i])
    );
  end

  // ==========================================================
  // registered damping outputs
  always_ff @(posedge clock) begin
    if (rst) begin
      loop_a_damp_factor <= DDG_DF_NONE;
      loop_a_gain_peak   <= DDG_GP_NONE;
      loop_b_damp_factor <= DDG_DF_NONE;
      loop_b_gain_peak   <= DDG_GP_NONE;
    end else begin
      loop_a_damp_factor <= factor_w[0];
      loop_a_gain_peak   <= peak_w[0];
      loop_b_damp_factor <= factor_w[1];
      loop_b_gain_peak   <= peak_w[1];
    end
  end

  // ==========================================================
  // detector gain conditions
  // second loop: enable bit set, analog feedback, locking
  assign b_gate = loop_b_detector_gain_on && loop_b_analog_mode
                  && loop_b_locking;
  // first loop: selection on, analog feedback, 8 kHz reference, locking
  assign a_gate = loop_a_gain_sel_on && loop_a_analog_mode
                  && loop_a_ref_8k && loop_a_locking;

  // second loop gain, zero while not applied
  always_ff @(posedge clock) begin
    if (rst) begin
      loop_b_detector_gain     <= 3'h0;
      loop_b_detector_gain_act <= 1'b0;
    end else begin
      loop_b_detector_gain_act <= b_gate;
      loop_b_detector_gain     <= b_gate ?
        second_reg[DDG_GAIN_LSB +: 3] : 3'h0;
    end
  end

  // first loop gain, zero while not applied
  always_ff @(posedge clock) begin
    if (rst) begin
      loop_a_detector_gain     <= 3'h0;
      loop_a_detector_gain_act <= 1'b0;
    end else begin
      loop_a_detector_gain_act <= a_gate;
      loop_a_detector_gain     <= a_gate ?
        first_reg[DDG_GAIN_LSB +: 3] : 3'h0;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // the code, gain field and readback antecedents wait for reset to be gone at their first edge, so an
  // input that stands high through a mid-run reset cannot trip those checks
  a_b_code5_70: assert property (
    (!rst && second_reg[2:0] == DDG_CODE_5 && bw_b == DDG_BW_70)
      |=> loop_b_damp_factor == DDG_DF_20)
    else $error("second loop code 5 at 70 Hz not 20");

  a_b_code4_18: assert property (
    (!rst && second_reg[2:0] == DDG_CODE_4 && bw_b == DDG_BW_18)
      |=> loop_b_damp_factor == DDG_DF_5)
    else $error("second loop code 4 at 18 Hz not 5");

  a_a_code4_35: assert property (
    (!rst && first_reg[2:0] == DDG_CODE_4 && bw_a == DDG_BW_35)
      |=> loop_a_damp_factor == DDG_DF_10)
    else $error("first loop code 4 at 35 Hz not 10");

  a_peak_tenth: assert property (
    loop_b_damp_factor == DDG_DF_10 |-> loop_b_gain_peak == DDG_GP_10)
    else $error("damping 10 without 0.06 dB peak");

  a_peak_onetwo: assert property (
    loop_a_damp_factor == DDG_DF_1P2 |-> loop_a_gain_peak == DDG_GP_1P2)
    else $error("damping 1.2 without 0.4 dB peak");

  a_b_gain_field: assert property (
    !rst && b_gate |=> loop_b_detector_gain == $past(second_reg[6:4]))
    else $error("second loop gain not from bits 6:4");

  a_b_gain_off: assert property (
    !loop_b_detector_gain_on |=> !loop_b_detector_gain_act
      && loop_b_detector_gain == 3'h0)
    else $error("second loop gain applied while disabled");

  a_a_gain_8k: assert property (
    loop_a_detector_gain_act |-> $past(loop_a_ref_8k)
      && $past(loop_a_gain_sel_on) && $past(loop_a_analog_mode))
    else $error("first loop gain without 8k analog select");

  a_b_gain_act: assert property (
    !$past(rst) |-> loop_b_detector_gain_act == $past(b_gate))
    else $error("second loop gain enable mismatch");

  a_unused_zero: assert property (
    second_reg[7] == 1'b0 && second_reg[3] == 1'b0
      && first_reg[7] == 1'b0 && first_reg[3] == 1'b0)
    else $error("unused bit stored");

  a_write_read: assert property (
    (!rst && reg_wr && reg_addr == DDG_OFS_FIRST) ##1
      (!rst && reg_rd && reg_addr == DDG_OFS_FIRST && !reg_wr)
      |=> reg_rdata == ($past(reg_wdata, 2) & DDG_WR_MASK))
    else $error("first loop readback wrong");

  c_b_gain_used: cover property (b_gate ##1 loop_b_detector_gain_act);
  c_a_gain_used: cover property (a_gate ##1 loop_a_detector_gain_act);
  c_damp_20:     cover property (loop_b_damp_factor == DDG_DF_20);
  c_rd_second:   cover property (reg_rd && reg_addr == DDG_OFS_SECOND);

endmodule

// ==== pkg/ddg_pkg.sv ====
// constants for the loop damping and detector gain register bank
package ddg_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] DDG_OFS_SECOND = 8'h6A;  // second loop damping
  localparam logic [7:0] DDG_OFS_FIRST  = 8'h6B;  // first loop damping
  localparam logic [7:0] DDG_RST_SECOND = 8'h13;  // value after reset
  localparam logic [7:0] DDG_RST_FIRST  = 8'h14;  // value after reset
  localparam logic [7:0] DDG_WR_MASK    = 8'h77;  // bits 7 and 3 unused
  localparam logic [7:0] DDG_RD_UNMAP   = 8'h00;  // unmapped read value

  // ==========================================================
  // field positions
  localparam int DDG_DAMP_LSB = 0;  // damping code [2:0]
  localparam int DDG_GAIN_LSB = 4;  // detector gain [6:4]

  // ==========================================================
  // bandwidth column of the damping table
  typedef enum logic [1:0] {
    DDG_BW_18,
    DDG_BW_35,
    DDG_BW_70
  } ddg_bw_e;

  // second loop bandwidth field encodings
  localparam logic [1:0] DDG_B_BW_18 = 2'h0;
  localparam logic [1:0] DDG_B_BW_35 = 2'h1;
  localparam logic [1:0] DDG_B_BW_70 = 2'h2;
  // first loop locked bandwidth field encodings
  localparam logic [1:0] DDG_A_BW_18 = 2'h3;
  localparam logic [1:0] DDG_A_BW_35 = 2'h0;
  localparam logic [1:0] DDG_A_BW_70 = 2'h1;

  // ==========================================================
  // damping codes
  localparam logic [2:0] DDG_CODE_1 = 3'h1;
  localparam logic [2:0] DDG_CODE_2 = 3'h2;
  localparam logic [2:0] DDG_CODE_3 = 3'h3;
  localparam logic [2:0] DDG_CODE_4 = 3'h4;
  localparam logic [2:0] DDG_CODE_5 = 3'h5;

  // damping factor in tenths
  localparam logic [7:0] DDG_DF_1P2 = 8'h0C;  // 1.2
  localparam logic [7:0] DDG_DF_2P5 = 8'h19;  // 2.5
  localparam logic [7:0] DDG_DF_5   = 8'h32;  // 5
  localparam logic [7:0] DDG_DF_10  = 8'h64;  // 10
  localparam logic [7:0] DDG_DF_20  = 8'hC8;  // 20
  localparam logic [7:0] DDG_DF_NONE = 8'h00; // undefined code

  // gain peak in hundredths of a dB
  localparam logic [5:0] DDG_GP_1P2 = 6'h28;  // 0.4 dB
  localparam logic [5:0] DDG_GP_2P5 = 6'h14;  // 0.2 dB
  localparam logic [5:0] DDG_GP_5   = 6'h0A;  // 0.1 dB
  localparam logic [5:0] DDG_GP_10  = 6'h06;  // 0.06 dB
  localparam logic [5:0] DDG_GP_20  = 6'h03;  // 0.03 dB
  localparam logic [5:0] DDG_GP_NONE = 6'h00; // undefined code

endpackage
